// file: rtl/byte_fifo.sv
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock_in, // Core clock
    input wire logic arst_n_in, // Async reset, active low
    input wire logic in_valid_in, // Write request
    output logic in_ready_out, // Room for a word
    input wire logic [WIDTH-1:0] in_data_in, // Write word
    output logic out_valid_out, // Output word valid
    input wire logic out_ready_in, // Drain accepts word
    output logic [WIDTH-1:0] out_data_out // Output word, registered
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic push, pop;

    // ============================================================
    // Pointers and output stage
    always_comb
    begin
        push = in_valid_in && (cnt_q != (AW + 1)'(DEPTH));
        pop = (cnt_q != '0) && (!ov_q || out_ready_in);
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        ov_d = ov_q && !out_ready_in;
        od_d = od_q;
        if (push)
        begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            ov_d = 1'b1;
            od_d = mem_q[rd_q];
        end
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end

    // Storage has no reset; only words below the count are ever read
    always_ff @(posedge clock_in)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    assign in_ready_out = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid_out = ov_q;
    assign out_data_out = od_q;
endmodule : byte_fifo

// file: rtl/flash_program_debug_port.sv
// Overview of operation
// - Programming mode stays on until a system reset.
// - Control register: 8-bit read/write, link address 0x02, resets to zero.
// - Data register: 8-bit read/write at link address 0xbf, carries commands and bytes.
// - Command bytes 0x06 read, 0x07 write, 0x08 page erase, 0x03 device erase.
// - Link clock arrives on the shared active-low reset pin.
// - Link address register picks the target of data reads and writes.
// - Link has a programmer-driven clock pin and a two-way data pin.
module flash_program_debug_port (
    input wire logic clock_in, // Core clock, 10 MHz
    input wire logic arst_n_in, // System reset, active low
    input wire logic link_clock_pin_in, // Link clock, shared reset pin
    input wire logic link_data_pin_in, // Data pin level
    output logic link_data_pin_out, // Data pin drive value
    output logic link_data_pin_oe_n_out, // Data pin drive enable, low drives
    output logic prog_enable_out, // Programming mode active
    output logic sys_reset_req_out, // Long low on shared pin
    output flash_program_debug_port_pkg::flash_cmd_t flash_cmd_out, // Decoded command
    output logic flash_cmd_valid_out, // Command pulse
    output logic [7:0] flash_byte_out, // Address or data byte
    output logic flash_byte_valid_out, // Byte valid
    input wire logic flash_byte_ready_in, // Flash side takes byte
    input wire logic flash_done_in, // Command finished
    input wire logic [7:0] flash_rdata_in, // Byte read from flash
    input wire logic flash_rdata_valid_in // Read byte strobe
);
    import flash_program_debug_port_pkg::*;

    // ============================================================
    // Link domain state
    link_state_t ls_q, ls_d;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] ins_q, ins_d;
    logic [7:0] sh_q, sh_d, addr_q, addr_d, ctrl_q, ctrl_d, data_q, data_d;
    logic stage_q, stage_d, pe_q, pe_d, wt_q, wt_d, dout_q, dout_d, oen_q, oen_d;
    logic ack_s1_q, ack_s2_q, rt_s1_q, rt_s2_q, rt_s3_q;
    logic commit, ctrl_wr, busy;
    logic [7:0] wbyte, rval;
    // Core-side handshake state, read by the link side through toggles
    logic pend_q, pend_d, ack_q, ack_d, rt_q, rt_d;
    logic [7:0] pbyte_q, pbyte_d, rd_byte_q, rd_byte_d, fb_q, fb_d;

    always_comb
    begin
        ls_d = ls_q;
        cnt_d = cnt_q + 3'h1;
        ins_d = ins_q;
        sh_d = sh_q;
        addr_d = addr_q;
        ctrl_d = ctrl_q;
        data_d = data_q;
        stage_d = stage_q;
        pe_d = pe_q;
        wt_d = wt_q;
        dout_d = 1'b1;
        oen_d = 1'b1;
        commit = 1'b0;
        busy = wt_q ^ ack_s2_q;
        wbyte = {link_data_pin_in, sh_q[7:1]};
        if (rt_s2_q ^ rt_s3_q)
        begin
            data_d = rd_byte_q;
        end
        case (addr_q)
            ADDR_CONTROL: rval = ctrl_q;
            ADDR_DATA: rval = data_q;
            default: rval = UNMAPPED_READ;
        endcase
        if (ins_q == INS_ADDR_READ)
        begin
            rval = addr_q;
        end
        case (ls_q)
            L_IDLE:
            begin
                cnt_d = 3'h0;
                if (!link_data_pin_in)
                begin
                    ls_d = L_INS;
                end
            end
            L_INS:
            begin
                ins_d = {ins_q[0], link_data_pin_in};
                if (cnt_q == 3'h1)
                begin
                    cnt_d = 3'h0;
                    ls_d = ins_d[0] ? L_WDATA : L_TURN;
                end
            end
            L_WDATA:
            begin
                sh_d = wbyte;
                if (cnt_q == 3'h7)
                begin
                    commit = 1'b1;
                    ls_d = L_IDLE;
                end
            end
            L_TURN:
            begin
                sh_d = {1'b1, rval[7:1]};
                dout_d = rval[0];
                oen_d = 1'b0;
                cnt_d = 3'h0;
                ls_d = L_RDATA;
            end
            L_RDATA:
            begin
                sh_d = {1'b1, sh_q[7:1]};
                if (cnt_q != 3'h7)
                begin
                    dout_d = sh_q[0];
                    oen_d = 1'b0;
                end
                else
                begin
                    ls_d = L_IDLE;
                end
            end
            default: ls_d = L_IDLE;
        endcase
        ctrl_wr = commit && (ins_q == INS_DATA_WRITE) && (addr_q == ADDR_CONTROL);
        if (commit && (ins_q == INS_ADDR_WRITE))
        begin
            addr_d = wbyte;
        end
        if (ctrl_wr)
        begin
            ctrl_d = wbyte;
            stage_d = (wbyte == UNLOCK_FIRST);
            if (stage_q && (wbyte == UNLOCK_SECOND))
            begin
                pe_d = 1'b1;
            end
        end
        if (commit && (ins_q == INS_DATA_WRITE) && (addr_q == ADDR_DATA) && !busy)
        begin
            data_d = wbyte;
            wt_d = pe_q ? ~wt_q : wt_q;
        end
    end

    // Only the system reset leaves programming mode
    always_ff @(posedge link_clock_pin_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ls_q <= L_IDLE;
            cnt_q <= 3'h0;
            ins_q <= 2'h0;
            sh_q <= 8'h00;
            addr_q <= ADDR_RESET;
            ctrl_q <= CONTROL_RESET;
            data_q <= DATA_RESET;
            stage_q <= 1'b0;
            pe_q <= 1'b0;
            wt_q <= 1'b0;
            dout_q <= 1'b1;
            oen_q <= 1'b1;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            rt_s1_q <= 1'b0;
            rt_s2_q <= 1'b0;
            rt_s3_q <= 1'b0;
        end
        else
        begin
            ls_q <= ls_d;
            cnt_q <= cnt_d;
            ins_q <= ins_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            ctrl_q <= ctrl_d;
            data_q <= data_d;
            stage_q <= stage_d;
            pe_q <= pe_d;
            wt_q <= wt_d;
            dout_q <= dout_d;
            oen_q <= oen_d;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            rt_s1_q <= rt_q;
            rt_s2_q <= rt_s1_q;
            rt_s3_q <= rt_s2_q;
        end
    end

    // ============================================================
    // Core domain state
    logic pin_s1_q, pin_s2_q, req_q, req_d;
    logic [$clog2(RESET_LOW_CYCLES + 1)-1:0] low_q, low_d;
    logic wt_s1_q, wt_s2_q, wt_s3_q, pe_s1_q, pe_s2_q;
    logic fbv_q, fbv_d, cmdv_q, cmdv_d, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_out_data;
    flash_cmd_t cmd_q, cmd_d;
    cmd_state_t cs_q, cs_d;

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(pend_q),
        .in_ready_out(f_in_ready),
        .in_data_in(pbyte_q),
        .out_valid_out(f_out_valid),
        .out_ready_in(f_out_ready),
        .out_data_out(f_out_data)
    );

    always_comb
    begin
        low_d = low_q;
        if (pin_s2_q)
        begin
            low_d = '0;
        end
        else if (low_q != $bits(low_q)'(RESET_LOW_CYCLES))
        begin
            low_d = low_q + 1'b1;
        end
        // Link clock lows are short; only a held low means reset
        req_d = (low_d == $bits(low_q)'(RESET_LOW_CYCLES));
        pend_d = pend_q;
        pbyte_d = pbyte_q;
        ack_d = ack_q;
        if (pend_q && f_in_ready)
        begin
            pend_d = 1'b0;
            ack_d = ~ack_q;
        end
        if (wt_s2_q ^ wt_s3_q)
        begin
            pend_d = 1'b1;
            pbyte_d = data_q;
        end
        rd_byte_d = flash_rdata_valid_in ? flash_rdata_in : rd_byte_q;
        rt_d = rt_q ^ flash_rdata_valid_in;
        f_out_ready = (cs_q == C_IDLE) || !fbv_q || flash_byte_ready_in;
        cmdv_d = 1'b0;
        cmd_d = cmd_q;
        cs_d = cs_q;
        fb_d = fb_q;
        fbv_d = fbv_q && !flash_byte_ready_in;
        // Done clears cs_d, but a byte arriving in the same cycle is judged by cs_q, so in C_OPERAND it goes out as an operand
        if (flash_done_in || !pe_s2_q)
        begin
            cs_d = C_IDLE;
        end
        if (f_out_valid && f_out_ready)
        begin
            if (cs_q == C_IDLE)
            begin
                cmdv_d = 1'b1;
                cs_d = C_OPERAND;
                case (f_out_data)
                    CODE_BLOCK_READ: cmd_d = CMD_BLOCK_READ;
                    CODE_BLOCK_WRITE: cmd_d = CMD_BLOCK_WRITE;
                    CODE_PAGE_ERASE: cmd_d = CMD_PAGE_ERASE;
                    CODE_DEVICE_ERASE: cmd_d = CMD_DEVICE_ERASE;
                    default:
                    begin
                        cmdv_d = 1'b0;
                        cs_d = C_IDLE;
                    end
                endcase
            end
            else
            begin
                fb_d = f_out_data;
                fbv_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            low_q <= '0;
            req_q <= 1'b0;
            wt_s1_q <= 1'b0;
            wt_s2_q <= 1'b0;
            wt_s3_q <= 1'b0;
            pe_s1_q <= 1'b0;
            pe_s2_q <= 1'b0;
            pend_q <= 1'b0;
            pbyte_q <= 8'h00;
            ack_q <= 1'b0;
            rd_byte_q <= 8'h00;
            rt_q <= 1'b0;
            cmd_q <= CMD_NONE;
            cmdv_q <= 1'b0;
            cs_q <= C_IDLE;
            fb_q <= 8'h00;
            fbv_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= link_clock_pin_in;
            pin_s2_q <= pin_s1_q;
            low_q <= low_d;
            req_q <= req_d;
            wt_s1_q <= wt_q;
            wt_s2_q <= wt_s1_q;
            wt_s3_q <= wt_s2_q;
            pe_s1_q <= pe_q;
            pe_s2_q <= pe_s1_q;
            pend_q <= pend_d;
            pbyte_q <= pbyte_d;
            ack_q <= ack_d;
            rd_byte_q <= rd_byte_d;
            rt_q <= rt_d;
            cmd_q <= cmd_d;
            cmdv_q <= cmdv_d;
            cs_q <= cs_d;
            fb_q <= fb_d;
            fbv_q <= fbv_d;
        end
    end

    assign link_data_pin_out = dout_q;
    assign link_data_pin_oe_n_out = oen_q;
    assign prog_enable_out = pe_s2_q;
    assign sys_reset_req_out = req_q;
    assign flash_cmd_out = cmd_q;
    assign flash_cmd_valid_out = cmdv_q;
    assign flash_byte_out = fb_q;
    assign flash_byte_valid_out = fbv_q;

    // ============================================================
    // Checks
    sequence s_read_turn;
        (ls_q == L_INS) && (cnt_q == 3'h1) && !link_data_pin_in;
    endsequence
    sequence s_read_drive;
        !oen_q [*8] ##1 oen_q;
    endsequence

    a_unlock_enable: assert property (@(posedge link_clock_pin_in) disable iff (!arst_n_in)
        ctrl_wr && stage_q && (wbyte == UNLOCK_SECOND) |=> pe_q)
        else $error("unlock sequence did not enable programming");
    a_unlock_guard: assert property (@(posedge link_clock_pin_in) disable iff (!arst_n_in)
        !pe_q && !(ctrl_wr && stage_q && (wbyte == UNLOCK_SECOND)) |=> !pe_q)
        else $error("programming enabled without ordered codes");
    a_mode_sticky: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        prog_enable_out |=> prog_enable_out [*4])
        else $error("programming mode left without reset");
    a_control_write: assert property (@(posedge link_clock_pin_in) disable iff (!arst_n_in)
        ctrl_wr |=> (ctrl_q == $past(wbyte)) && (stage_q == ($past(wbyte) == UNLOCK_FIRST)))
        else $error("control register write lost");
    a_address_select: assert property (@(posedge link_clock_pin_in) disable iff (!arst_n_in)
        commit && (ins_q == INS_ADDR_WRITE) |=> addr_q == $past(wbyte))
        else $error("address register write lost");
    a_read_drive: assert property (@(posedge link_clock_pin_in) disable iff (!arst_n_in)
        s_read_turn ##1 (ls_q == L_TURN) |=> s_read_drive)
        else $error("read data not driven for eight bits");
    a_cmd_decode: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        f_out_valid && f_out_ready && (cs_q == C_IDLE) && (f_out_data == CODE_PAGE_ERASE)
        |=> flash_cmd_valid_out && (flash_cmd_out == CMD_PAGE_ERASE))
        else $error("page erase code decoded wrongly");
    a_reset_filter: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $rose(sys_reset_req_out) |-> $past(low_q) == $bits(low_q)'(RESET_LOW_CYCLES - 1))
        else $error("reset request not tied to held low");
    a_byte_forward: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $rose(pend_q) |-> pbyte_q == data_q ##[1:8] !pend_q)
        else $error("data byte not moved into the buffer");
endmodule : flash_program_debug_port

// file: rtl/flash_program_debug_port_pkg.sv
package flash_program_debug_port_pkg;
    // ============================================================
    // Link register selection
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_DATA = 8'hbf;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ============================================================
    // Unlock codes and flash command codes
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    localparam logic [7:0] CODE_BLOCK_READ = 8'h06;
    localparam logic [7:0] CODE_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CODE_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CODE_DEVICE_ERASE = 8'h03;
    // ============================================================
    // Frame instruction field, sent after the start bit
    localparam logic [1:0] INS_DATA_READ = 2'h0;
    localparam logic [1:0] INS_DATA_WRITE = 2'h1;
    localparam logic [1:0] INS_ADDR_READ = 2'h2;
    localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 4;
    // ============================================================
    // Timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int RESET_LOW_TIME_NS = 20000;
    localparam int RESET_LOW_CYCLES = (RESET_LOW_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // ============================================================
    // Types
    typedef enum logic [2:0] {CMD_NONE, CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE,
        CMD_DEVICE_ERASE} flash_cmd_t;
    typedef enum logic [2:0] {L_IDLE, L_INS, L_WDATA, L_TURN, L_RDATA} link_state_t;
    typedef enum logic {C_IDLE, C_OPERAND} cmd_state_t;
endpackage : flash_program_debug_port_pkg

// file: sim/flash_program_debug_port_test.sv
module flash_program_debug_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_program_debug_port_pkg::*;

    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic flash_byte_ready_in = 1'b1;
    logic flash_done_in = 1'b0;
    logic [7:0] flash_rdata_in = 8'h00;
    logic flash_rdata_valid_in = 1'b0;
    logic link_clk, drv, drv_en, link_level, pin_out, oe_n, prog_en, sys_rst_req;
    logic cmd_valid, fbyte_valid;
    flash_cmd_t flash_cmd, last_cmd;
    logic [7:0] fbyte, last_byte, v;
    int error_cnt = 0;
    int tests_run = 0;
    int cmd_cnt = 0;
    int byte_cnt = 0;
    logic [7:0] codes [4] = '{CODE_BLOCK_READ, CODE_BLOCK_WRITE, CODE_PAGE_ERASE,
        CODE_DEVICE_ERASE};
    flash_cmd_t cmds [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};

    always #50 clock_in = ~clock_in;
    // Pull-up keeps the data line high when nobody drives it
    assign link_level = !oe_n ? pin_out : (drv_en ? drv : 1'b1);

    flash_program_debug_port flash_program_debug_port_i (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .link_clock_pin_in(link_clk),
        .link_data_pin_in(link_level), .link_data_pin_out(pin_out),
        .link_data_pin_oe_n_out(oe_n), .prog_enable_out(prog_en),
        .sys_reset_req_out(sys_rst_req), .flash_cmd_out(flash_cmd),
        .flash_cmd_valid_out(cmd_valid), .flash_byte_out(fbyte),
        .flash_byte_valid_out(fbyte_valid), .flash_byte_ready_in(flash_byte_ready_in),
        .flash_done_in(flash_done_in), .flash_rdata_in(flash_rdata_in),
        .flash_rdata_valid_in(flash_rdata_valid_in));

    link_programmer link_programmer_i (.link_clk_out(link_clk), .drive_out(drv),
        .drive_en_out(drv_en), .link_level_in(link_level));

    // ============================================================
    // Flash side monitor
    always @(posedge clock_in)
    begin
        if (cmd_valid === 1'b1)
        begin
            cmd_cnt++;
            last_cmd = flash_cmd;
        end
        if (fbyte_valid === 1'b1 && flash_byte_ready_in === 1'b1)
        begin
            byte_cnt++;
            last_byte = fbyte;
        end
    end

    // ============================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] dummy;
        link_programmer_i.frame(INS_ADDR_WRITE, addr, dummy);
        link_programmer_i.frame(INS_DATA_WRITE, data, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        logic [7:0] dummy;
        link_programmer_i.frame(INS_ADDR_WRITE, addr, dummy);
        link_programmer_i.frame(INS_DATA_READ, 8'h00, data);
    endtask : rd

    task automatic wait_cmd(input int target);
        for (int i = 0; i < 50 && cmd_cnt < target; i++)
            @(negedge clock_in);
    endtask : wait_cmd

    task automatic done_pulse();
        @(negedge clock_in);
        flash_done_in = 1'b1;
        @(negedge clock_in);
        flash_done_in = 1'b0;
    endtask : done_pulse

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ============================================================
    // Tests
    initial
    begin
        repeat (4) @(negedge clock_in);
        arst_n_in = 1'b1;
        @(negedge clock_in);
        rd(ADDR_CONTROL, v);
        check(v, CONTROL_RESET);
        rd(ADDR_DATA, v);
        check(v, DATA_RESET);
        link_programmer_i.frame(INS_ADDR_READ, 8'h00, v);
        check(v, ADDR_DATA);
        wr(ADDR_CONTROL, 8'h5a);
        rd(ADDR_CONTROL, v);
        check(v, 8'h5a);
        wr(8'h33, 8'h77);
        rd(8'h33, v);
        check(v, UNMAPPED_READ);
        rd(ADDR_CONTROL, v);
        check(v, 8'h5a);
        $display("Test registers done");

        // Locked: command stored but never forwarded
        wr(ADDR_DATA, CODE_BLOCK_READ);
        repeat (30) @(negedge clock_in);
        check(8'(cmd_cnt), 8'h00);
        rd(ADDR_DATA, v);
        check(v, CODE_BLOCK_READ);
        wr(ADDR_CONTROL, UNLOCK_SECOND);
        wr(ADDR_CONTROL, UNLOCK_FIRST);
        wr(ADDR_CONTROL, 8'h05);
        wr(ADDR_CONTROL, UNLOCK_SECOND);
        repeat (30) @(negedge clock_in);
        check({7'h00, prog_en}, 8'h00);
        wr(ADDR_CONTROL, UNLOCK_FIRST);
        wr(ADDR_CONTROL, UNLOCK_SECOND);
        for (int i = 0; i < 20 && prog_en !== 1'b1; i++)
            @(negedge clock_in);
        check({7'h00, prog_en}, 8'h01);
        $display("Test unlock done");

        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_DATA, codes[i]);
            wait_cmd(i + 1);
            check(8'(cmd_cnt), 8'(i + 1));
            check({5'h00, last_cmd}, {5'h00, cmds[i]});
            done_pulse();
        end
        wr(ADDR_DATA, 8'h55);
        repeat (30) @(negedge clock_in);
        check(8'(cmd_cnt), 8'h04);
        // Operand bytes held back while the flash side stalls
        wr(ADDR_DATA, CODE_BLOCK_WRITE);
        wait_cmd(5);
        flash_byte_ready_in = 1'b0;
        wr(ADDR_DATA, 8'ha5);
        wr(ADDR_DATA, 8'h5b);
        repeat (10) @(negedge clock_in);
        check(8'(byte_cnt), 8'h00);
        check({7'h00, fbyte_valid}, 8'h01);
        check(fbyte, 8'ha5);
        flash_byte_ready_in = 1'b1;
        for (int i = 0; i < 20 && byte_cnt < 2; i++)
            @(negedge clock_in);
        check(8'(byte_cnt), 8'h02);
        check(last_byte, 8'h5b);
        done_pulse();
        flash_rdata_in = 8'h3c;
        flash_rdata_valid_in = 1'b1;
        @(negedge clock_in);
        flash_rdata_valid_in = 1'b0;
        rd(ADDR_DATA, v);
        check(v, 8'h3c);
        check({7'h00, prog_en}, 8'h01);
        $display("Test commands done");

        // Short low is a clock pulse, long low a reset request
        link_programmer_i.pin_set(1'b0);
        repeat (150) @(negedge clock_in);
        check({7'h00, sys_rst_req}, 8'h00);
        repeat (100) @(negedge clock_in);
        check({7'h00, sys_rst_req}, 8'h01);
        link_programmer_i.pin_set(1'b1);
        repeat (5) @(negedge clock_in);
        check({7'h00, sys_rst_req}, 8'h00);
        arst_n_in = 1'b0;
        link_programmer_i.idle(3);
        @(negedge clock_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        check({7'h00, prog_en}, 8'h00);
        rd(ADDR_CONTROL, v);
        check(v, CONTROL_RESET);
        $display("Test reset done");
        report_and_stop();
    end

    // About 150 us of traffic expected
    initial
    begin
        #1ms;
        error_cnt++;
        report_and_stop();
    end
endmodule : flash_program_debug_port_test

// file: sim/link_programmer.sv
// ============================================================
// Programmer side of the two-wire debug link
module link_programmer (
    output logic link_clk_out, // Link clock, stands high between frames
    output logic drive_out, // Data value when driving
    output logic drive_en_out, // High while the programmer drives data
    input wire logic link_level_in // Resolved data pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_NS = 80;

    initial
    begin
        link_clk_out = 1'b1;
        drive_out = 1'b1;
        drive_en_out = 1'b0;
    end

    // Data changes only while the clock is low
    task automatic tick(input logic bit_val, input logic drive);
        link_clk_out = 1'b0;
        drive_en_out = drive;
        drive_out = bit_val;
        #HALF_NS;
        link_clk_out = 1'b1;
        #HALF_NS;
    endtask : tick

    task automatic frame(input logic [1:0] ins, input logic [7:0] wdata,
        output logic [7:0] rdata);
        rdata = 8'h00;
        tick(1'b0, 1'b1);
        tick(ins[1], 1'b1);
        tick(ins[0], 1'b1);
        if (ins[0])
        begin
            for (int i = 0; i < 8; i++)
                tick(wdata[i], 1'b1);
        end
        else
        begin
            // Released from the turnaround on, read bits sampled late in the high half
            for (int i = 0; i < 8; i++)
            begin
                tick(1'b0, 1'b0);
                rdata[i] = link_level_in;
            end
            tick(1'b0, 1'b0);
        end
        drive_en_out = 1'b0;
        drive_out = 1'b1;
        // Clock stays high; keeps the release apart from the next start bit
        #HALF_NS;
    endtask : frame

    task automatic idle(input int n);
        for (int i = 0; i < n; i++)
            tick(1'b1, 1'b0);
    endtask : idle

    // Shared pin doubles as the active-low reset input
    task automatic pin_set(input logic level);
        link_clk_out = level;
    endtask : pin_set
endmodule : link_programmer
